// ===== pfm_pkg.sv
// Package: register map, field layout and types of the pin function mux
package pfm_pkg;

	// Register byte offsets (APB, one aligned word each)
	localparam logic [11:0] OFF_WPROT   = 12'h000;
	localparam logic [11:0] OFF_MODE    = 12'h004;
	localparam logic [11:0] OFF_DIR     = 12'h008;
	localparam logic [11:0] OFF_FLTEN   = 12'h00c;
	localparam logic [11:0] OFF_STATUS  = 12'h010;
	localparam logic [11:0] OFF_IRQCTL  = 12'h040;
	localparam logic [11:0] OFF_FLTCLK  = 12'h080;
	localparam logic [11:0] OFF_PFS     = 12'h100;

	// Function-select layout
	localparam int BIT_ANALOG = 7;
	localparam int BIT_IRQSEL = 6;
	localparam int PSEL_HI    = 4;
	localparam int PSEL_W     = 5;
	localparam logic [7:0] PFS_RESET    = 8'h00;
	localparam logic [7:0] PFS_WMASK_AI = 8'hdf;

	// Write-protect layout
	localparam int BIT_FRWE = 6;
	localparam int BIT_PBWD = 7;
	localparam logic [7:0] WPROT_RESET = 8'h80;

	// Detect modes
	localparam logic [1:0] DET_LOW  = 2'h0;
	localparam logic [1:0] DET_FALL = 2'h1;
	localparam logic [1:0] DET_RISE = 2'h2;
	localparam logic [1:0] DET_BOTH = 2'h3;

	// Filter clock choices: PCLK, /8, /32, /64
	localparam logic [1:0] FCK_DIV1  = 2'h0;
	localparam logic [1:0] FCK_DIV8  = 2'h1;
	localparam logic [1:0] FCK_DIV32 = 2'h2;
	localparam logic [1:0] FCK_DIV64 = 2'h3;
	localparam int DIV8_CNT  = 8;
	localparam int DIV32_CNT = 32;
	localparam int DIV64_CNT = 64;
	localparam int FLT_SAMPLES = 3;

	typedef struct packed {
		logic       analogSelect;
		logic       irqInputSelect;
		logic       unused5;
		logic [4:0] periphSelect;
	} pfm_pfs_t;

	typedef struct packed {
		logic [11:0] paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} pfm_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} pfm_apb_rsp_t;

endpackage : pfm_pkg

// ===== pfm_irq_filter.sv
// One IRQ channel: noise filter and trigger detection
`timescale 1ns/10ps
module pfm_irq_filter
	import pfm_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	input  wire logic       sampleEn,
	input  wire logic       filterEnable,
	input  wire logic [1:0] irqDetectMode,
	input  wire logic       pinIn,
	output logic            irqTrigger,
	output logic            levelOut
);

	logic [1:0] histQ;
	logic       fltQ;
	logic       prevQ;
	logic       lvl;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			histQ <= 2'h3;
			fltQ  <= 1'b1;
		end else if (sampleEn) begin
			histQ <= {histQ[0], pinIn};
			if (histQ[1] == pinIn && histQ[0] == pinIn) begin
				fltQ <= pinIn;
			end
		end
	end

	assign lvl = filterEnable ? fltQ : pinIn;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prevQ      <= 1'b1;
			irqTrigger <= 1'b0;
		end else begin
			prevQ <= lvl;
			unique case (irqDetectMode)
				DET_LOW:  irqTrigger <= !lvl;
				DET_FALL: irqTrigger <= prevQ && !lvl;
				DET_RISE: irqTrigger <= !prevQ && lvl;
				DET_BOTH: irqTrigger <= prevQ != lvl;
			endcase
		end
	end

	assign levelOut = prevQ;

endmodule : pfm_irq_filter

// ===== pfm_pin_mux.sv
// Pin function multiplexer with IRQ path and APB register file
// How it works
// - Each pin has an 8-bit select: analog b7, IRQ b6, peripheral b4..0, reset zero.
// - Analog bit exists only on analog-capable pins; one puts pin in analog mode.
// - IRQ bit exists only on IRQ-capable pins; one routes pin to interrupt input.
// - Every pin has the peripheral selector choosing its connected function.
// - Select registers reset write-protected and ignore writes until unlocked.
// - Same function on several pins is not blocked; result is undefined.
// - IRQ bit plus peripheral selector serve interrupt and peripheral together.
// - IRQ detects low level, falling, rising or both edges; falling is 0x01.
// - Filter samples at clock or /8, /32, /64; rejects pulses under three samples.
// - Enabled filtering delays the trigger by the filter sampling time.
// - Each IRQ pin has its own filter enable.
// - Each IRQ pin has its own filter clock choice.
// - Writing 0x40 selects IRQ input only.
// - Selector 0x0A on the example pin connects serial channel 5 receive.
// - Every pin resets as an input.
// - Port mode zero gives GPIO, one gives the selected peripheral; resets zero.
// - With IRQ bit cleared a pin can never be an interrupt input.
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
module pfm_pin_mux
	import pfm_pkg::*;
#(
	parameter int                 NPINS       = 8,
	parameter int                 NFUNC       = 32,
	parameter logic [NPINS-1:0]   ANALOG_CAP  = 8'h0f,
	parameter logic [NPINS-1:0]   IRQ_CAP     = 8'hff,
	parameter int                 SERIAL5_RECEIVE_INPUT_PIN    = 2,
	parameter logic [4:0]         SERIAL5_RECEIVE_INPUT_SEL    = 5'h0a
)
(
	input  wire logic                core_clk,
	input  wire logic                arst_n,
	input  wire pfm_apb_req_t        apbReq,
	output pfm_apb_rsp_t             apbRsp,
	input  wire logic [NPINS-1:0]    pinIn,
	input  wire logic [NPINS-1:0]    gpioOut,
	output logic [NPINS-1:0]         pinOut,
	output logic [NPINS-1:0]         pinOe,
	output logic [NPINS-1:0]         analogMode,
	output logic [NPINS-1:0]         irqTrigger,
	input  wire logic [NFUNC-1:0]    periphOut,
	input  wire logic [NFUNC-1:0]    periphOe,
	output logic [NFUNC-1:0]         periphIn,
	output logic                     serial5ReceiveInput
);

	pfm_pfs_t [NPINS-1:0] pinFunctionSelectQ;
	logic [7:0]           pinWriteProtectQ;
	logic [NPINS-1:0]     portModeBitQ;
	logic [NPINS-1:0]     portDirectionBitQ;
	logic [NPINS-1:0]     irqFilterEnableQ;
	logic [1:0]           irqDetectModeQ [NPINS];
	logic [1:0]           irqFilterClockQ [NPINS];
	logic [5:0]           divCntQ;
	logic                 en8;
	logic                 en32;
	logic                 en64;
	logic [NPINS-1:0]     irqLevel;
	logic                 wrAcc;
	logic                 rdAcc;
	logic [11:0]          addr;
	logic [31:0]          rdData;
	logic [31:0]          prdataQ;
	logic                 hit;

	assign addr  = apbReq.paddr;
	assign wrAcc = apbReq.psel && apbReq.penable && apbReq.pwrite;
	assign rdAcc = apbReq.psel && apbReq.penable && !apbReq.pwrite;

	// Zero-wait slave: always ready, error on unmapped address
	// Whole struct from one assignment; read data comes from its own register
	assign apbRsp = '{prdata: prdataQ, pready: 1'b1,
		pslverr: apbReq.psel && apbReq.penable && !hit};

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pinWriteProtectQ <= WPROT_RESET;
		end else if (wrAcc && addr == OFF_WPROT) begin
			// Enable bit only changes while write-disable is clear
			if (!pinWriteProtectQ[BIT_PBWD]) begin
				pinWriteProtectQ[BIT_FRWE] <= apbReq.pwdata[BIT_FRWE];
			end
			pinWriteProtectQ[BIT_PBWD] <= apbReq.pwdata[BIT_PBWD];
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			portModeBitQ      <= '0;
			portDirectionBitQ <= '0;
		end else if (wrAcc) begin
			if (addr == OFF_MODE) begin
				portModeBitQ <= apbReq.pwdata[NPINS-1:0];
			end
			if (addr == OFF_DIR) begin
				portDirectionBitQ <= apbReq.pwdata[NPINS-1:0];
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			irqFilterEnableQ <= '0;
		end else if (wrAcc && addr == OFF_FLTEN) begin
			irqFilterEnableQ <= apbReq.pwdata[NPINS-1:0];
		end
	end

	// Filter sampling enables from one free-running divider
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			divCntQ <= '0;
		end else begin
			divCntQ <= divCntQ + 6'h01;
		end
	end
	assign en8  = divCntQ[2:0] == 3'h7;
	assign en32 = divCntQ[4:0] == 5'h1f;
	assign en64 = divCntQ == 6'h3f;

	genvar i;
	generate
		for (i = 0; i < NPINS; i++) begin : gPin
			localparam logic [11:0] PFS_A = OFF_PFS + 12'(4 * i);
			localparam logic [11:0] CTL_A = OFF_IRQCTL + 12'(4 * i);
			localparam logic [11:0] FCK_A = OFF_FLTCLK + 12'(4 * i);
			logic [7:0] wmask;
			logic       smp;
			logic       irqRaw;

			assign wmask = PFS_WMASK_AI
				& ~(ANALOG_CAP[i] ? 8'h00 : 8'h80)
				& ~(IRQ_CAP[i] ? 8'h00 : 8'h40);

			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					pinFunctionSelectQ[i] <= PFS_RESET;
				end else if (wrAcc && addr == PFS_A && pinWriteProtectQ[BIT_FRWE]) begin
					pinFunctionSelectQ[i] <= apbReq.pwdata[7:0] & wmask;
				end
			end

			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					irqDetectModeQ[i]  <= DET_LOW;
					irqFilterClockQ[i] <= FCK_DIV1;
				end else if (wrAcc) begin
					if (addr == CTL_A) begin
						irqDetectModeQ[i] <= apbReq.pwdata[1:0];
					end
					if (addr == FCK_A) begin
						irqFilterClockQ[i] <= apbReq.pwdata[1:0];
					end
				end
			end

			always_comb begin
				unique case (irqFilterClockQ[i])
					FCK_DIV1:  smp = 1'b1;
					FCK_DIV8:  smp = en8;
					FCK_DIV32: smp = en32;
					FCK_DIV64: smp = en64;
				endcase
			end

			pfm_irq_filter uFilt (
				.core_clk      (core_clk),
				.arst_n        (arst_n),
				.sampleEn      (smp),
				.filterEnable  (irqFilterEnableQ[i]),
				.irqDetectMode (irqDetectModeQ[i]),
				.pinIn         (pinIn[i]),
				.irqTrigger    (irqRaw),
				.levelOut      (irqLevel[i])
			);

			assign irqTrigger[i] = irqRaw && pinFunctionSelectQ[i].irqInputSelect;
			assign analogMode[i] = pinFunctionSelectQ[i].analogSelect;

			always_comb begin
				if (pinFunctionSelectQ[i].analogSelect) begin
					pinOut[i] = 1'b0;
					pinOe[i]  = 1'b0;
				end else if (portModeBitQ[i]) begin
					pinOut[i] = periphOut[pinFunctionSelectQ[i].periphSelect];
					pinOe[i]  = periphOe[pinFunctionSelectQ[i].periphSelect];
				end else begin
					pinOut[i] = gpioOut[i];
					pinOe[i]  = portDirectionBitQ[i];
				end
			end
		end
	endgenerate

	// Peripheral inputs: several pins on one function OR together, undefined use
	always_comb begin
		periphIn = '0;
		for (int p = 0; p < NPINS; p++) begin
			if (portModeBitQ[p] && !pinFunctionSelectQ[p].analogSelect) begin
				periphIn[pinFunctionSelectQ[p].periphSelect] =
					periphIn[pinFunctionSelectQ[p].periphSelect] | pinIn[p];
			end
		end
	end

	assign serial5ReceiveInput = periphIn[SERIAL5_RECEIVE_INPUT_SEL];

	always_comb begin
		rdData = '0;
		hit    = 1'b0;
		if (addr == OFF_WPROT) begin
			rdData[7:0] = pinWriteProtectQ;
			hit = 1'b1;
		end
		if (addr == OFF_MODE) begin
			rdData[NPINS-1:0] = portModeBitQ;
			hit = 1'b1;
		end
		if (addr == OFF_DIR) begin
			rdData[NPINS-1:0] = portDirectionBitQ;
			hit = 1'b1;
		end
		if (addr == OFF_FLTEN) begin
			rdData[NPINS-1:0] = irqFilterEnableQ;
			hit = 1'b1;
		end
		if (addr == OFF_STATUS) begin
			rdData[NPINS-1:0] = irqLevel;
			hit = 1'b1;
		end
		for (int p = 0; p < NPINS; p++) begin
			if (addr == OFF_PFS + 12'(4 * p)) begin
				rdData[7:0] = pinFunctionSelectQ[p];
				hit = 1'b1;
			end
			if (addr == OFF_IRQCTL + 12'(4 * p)) begin
				rdData[1:0] = irqDetectModeQ[p];
				hit = 1'b1;
			end
			if (addr == OFF_FLTCLK + 12'(4 * p)) begin
				rdData[1:0] = irqFilterClockQ[p];
				hit = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prdataQ <= '0;
		end else if (apbReq.psel && !apbReq.penable && !apbReq.pwrite) begin
			prdataQ <= rdData;
		end
	end

endmodule : pfm_pin_mux

// ===== pfm_pin_mux_checker.sv
// Port assertions for the pin function mux
`timescale 1ns/10ps
module pfm_pin_mux_checker
	import pfm_pkg::*;
#(
	parameter logic [7:0] ANALOG_CAP = 8'h0f
)
(
	input wire logic         core_clk,
	input wire logic         arst_n,
	input wire pfm_apb_req_t apbReq,
	input wire pfm_apb_rsp_t apbRsp,
	input wire logic [7:0]   pinOe,
	input wire logic [7:0]   analogMode,
	input wire logic [7:0]   irqTrigger,
	input wire logic [31:0]  periphIn,
	input wire logic         serial5ReceiveInput
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	logic       wDis_q;
	logic       wEn_q;
	logic [7:0] irq_input_select_q;
	wire        acc = apbReq.psel && apbReq.penable;
	wire        wr  = acc && apbReq.pwrite;
	wire        pfs = apbReq.paddr[11:5] == 7'h08;
	// Shadow of the unlock state, so locked writes can be recognised
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n) begin
			wDis_q <= 1'b1;
			wEn_q  <= 1'b0;
		end else if (wr && apbReq.paddr == OFF_WPROT) begin
			wDis_q <= apbReq.pwdata[BIT_PBWD];
			if (!wDis_q) wEn_q <= apbReq.pwdata[BIT_FRWE];
		end
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n) irq_input_select_q <= 8'h00;
		else if (wr && wEn_q && pfs) irq_input_select_q[apbReq.paddr[4:2]] <= apbReq.pwdata[BIT_IRQSEL];
	property p_rst; $rose(arst_n) |-> (pinOe == 8'h00 && analogMode == 8'h00)[*2]; endproperty
	a_rst: assert property (p_rst) else $error("pins not input after reset");
	property p_lock; wr && !wEn_q && pfs |=> $stable(analogMode); endproperty
	a_lock: assert property (p_lock) else $error("locked write took effect");
	property p_anaSet; wr && wEn_q && apbReq.paddr == OFF_PFS |=>
		analogMode[0] == $past(apbReq.pwdata[BIT_ANALOG]); endproperty
	a_anaSet: assert property (p_anaSet) else $error("analog bit not applied");
	property p_anaOe; (pinOe & analogMode) == 8'h00; endproperty
	a_anaOe: assert property (p_anaOe) else $error("analog pin driven");
	property p_anaCap; (analogMode & ~ANALOG_CAP) == 8'h00; endproperty
	a_anaCap: assert property (p_anaCap) else $error("analog on incapable pin");
	property p_noIrq; (irqTrigger & ~irq_input_select_q) == 8'h00; endproperty
	a_noIrq: assert property (p_noIrq) else $error("trigger without irq select");
	property p_ser5; serial5ReceiveInput == periphIn[10]; endproperty
	a_ser5: assert property (p_ser5) else $error("serial input mismatch");
	property p_err; acc && apbReq.paddr == 12'hffc |-> apbRsp.pslverr; endproperty
	a_err: assert property (p_err) else $error("unmapped access accepted");
	c_irq: cover property (|irqTrigger);
	c_ana: cover property (|analogMode);
	c_lock: cover property (wr && !wEn_q && pfs);
endmodule : pfm_pin_mux_checker
bind pfm_pin_mux pfm_pin_mux_checker #(.ANALOG_CAP(ANALOG_CAP)) chk (.core_clk, .arst_n,
	.apbReq, .apbRsp, .pinOe, .analogMode, .irqTrigger, .periphIn, .serial5ReceiveInput);

// ===== pfm_pad_model.sv
// Far side: pads with board drivers and pull-ups
`timescale 1ns/10ps
module pfm_pad_model
(
	input wire logic [7:0] pinOut,
	input wire logic [7:0] pinOe,
	input wire logic [7:0] extLevel,
	input wire logic [7:0] extDrive,
	output logic [7:0]     pinIn
);
	// Device drive wins; an undriven pad floats up to its pull-up
	assign pinIn = (pinOe & pinOut) | (~pinOe & ((extDrive & extLevel) | ~extDrive));
endmodule : pfm_pad_model

// ===== pfm_pin_mux_test.sv
// Self-checking bench for the pin function mux
`timescale 1ns/10ps
module pfm_pin_mux_test import pfm_pkg::*;;
	logic         core_clk = 1'b0;
	logic         arst_n = 1'b0;
	pfm_apb_req_t apbReq = '0;
	pfm_apb_rsp_t apbRsp;
	logic [7:0]   pinIn, pinOut, pinOe, analogMode, irqTrigger, expA;
	logic [7:0]   gpioOut = 8'h00, extLevel = 8'hff, extDrive = 8'hff;
	logic [31:0]  periphOut = '0, periphOe = '0, periphIn, rd, seed = 32'hb7d0b1b6;
	logic         ser5, err;
	int           fails = 0, n_checks = 0, trig = 0, d;
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) if (irqTrigger[3] === 1'b1) trig++;
	pfm_pin_mux dut (.core_clk(core_clk), .arst_n(arst_n), .apbReq(apbReq), .apbRsp(apbRsp),
		.pinIn(pinIn), .gpioOut(gpioOut), .pinOut(pinOut), .pinOe(pinOe),
		.analogMode(analogMode), .irqTrigger(irqTrigger), .periphOut(periphOut),
		.periphOe(periphOe), .periphIn(periphIn), .serial5ReceiveInput(ser5));
	pfm_pad_model pads (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel),
		.extDrive(extDrive), .pinIn(pinIn));
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt
	function automatic logic [31:0] expPfs(input int p, input logic [7:0] v);
		return {24'h0, v & {p < 4, 7'h5f}};
	endfunction : expPfs
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t value %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chkCnt(input int got, input int exp);
		n_checks++;
		if (got != exp) begin
			fails++;
			$display("[ERR] %0t count %0d expected %0d", $time, got, exp);
		end
	endtask : chkCnt
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		@(posedge core_clk);
		apbReq <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: v};
		@(posedge core_clk);
		apbReq.penable <= 1'b1;
		do @(posedge core_clk); while (apbRsp.pready !== 1'b1);
		rd = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
	endtask : apb
	task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdChk
	// Long settle so even the slowest filter rate has drained before counting
	task automatic trigRun(input int n, input int exp);
		repeat (400) @(posedge core_clk);
		trig = 0;
		extLevel[3] <= 1'b0;
		repeat (n) @(posedge core_clk);
		extLevel[3] <= 1'b1;
		repeat (400) @(posedge core_clk);
		chkCnt(trig, exp);
	endtask : trigRun
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	initial begin
		#400000;
		fails++;
		summarize();
	end
	initial begin
		repeat (5) @(posedge core_clk);
		arst_n <= 1'b1;
		gpioOut <= seed[15:8];
		periphOut <= seed;
		rdChk(OFF_WPROT, 32'h80);
		rdChk(OFF_PFS, 32'h0);
		rdChk(OFF_DIR, 32'h0);
		rdChk(OFF_MODE, 32'h0);
		apb(1'b1, OFF_PFS, 32'h80);
		rdChk(OFF_PFS, 32'h0);
		apb(1'b1, OFF_WPROT, 32'hc0);
		rdChk(OFF_WPROT, 32'h80);
		apb(1'b1, OFF_WPROT, 32'h00);
		rdChk(OFF_WPROT, 32'h0);
		apb(1'b1, OFF_WPROT, 32'h40);
		rdChk(OFF_WPROT, 32'h40);
		apb(1'b1, 12'hffc, 32'h0);
		chk(err, 1'b1);
		$display("unlock test done");
		for (int i = 0; i < 8; i++) begin
			seed = nxt(seed);
			expA[i] = (i < 4) && seed[7];
			apb(1'b1, OFF_PFS + 12'(4 * i), seed);
			rdChk(OFF_PFS + 12'(4 * i), expPfs(i, seed[7:0]));
		end
		chk(analogMode, expA);
		$display("select test done");
		apb(1'b1, OFF_PFS + 12'hc, 32'h40);
		rdChk(OFF_PFS + 12'hc, 32'h40);
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, OFF_IRQCTL + 12'hc, m);
			trigRun(8, (m == 0) ? 8 : (m == 3) ? 2 : 1);
		end
		apb(1'b1, OFF_IRQCTL + 12'hc, DET_FALL);
		apb(1'b1, OFF_FLTEN, 32'h8);
		for (int f = 0; f < 4; f++) begin
			d = f == 0 ? 1 : f == 1 ? DIV8_CNT : f == 2 ? DIV32_CNT : DIV64_CNT;
			apb(1'b1, OFF_FLTCLK + 12'hc, f);
			trigRun(2 * d, 0);
			trigRun(5 * d, 1);
		end
		apb(1'b1, OFF_FLTEN, 32'h0);
		apb(1'b1, OFF_PFS + 12'hc, 32'h0a);
		trigRun(8, 0);
		apb(1'b1, OFF_PFS + 12'hc, 32'h4a);
		trigRun(8, 1);
		$display("irq test done");
		apb(1'b1, OFF_PFS + 12'h8, 32'h0a);
		apb(1'b1, OFF_MODE, 32'h4);
		for (int k = 0; k < 4; k++) begin
			seed = nxt(seed);
			@(posedge core_clk);
			extLevel[2] <= seed[0];
			@(negedge core_clk) chk(ser5, seed[0]);
		end
		@(posedge core_clk);
		extDrive[2] <= 1'b0;
		periphOe[10] <= 1'b1;
		@(negedge core_clk) chk({pinOe[2], pinOut[2]}, {1'b1, periphOut[10]});
		apb(1'b1, OFF_MODE, 32'h0);
		@(negedge core_clk) chk({pinOe[2], ser5}, 2'b00);
		@(posedge core_clk);
		gpioOut[7] <= 1'b0;
		apb(1'b1, OFF_DIR, 32'h80);
		@(negedge core_clk) chk({pinOe[7], pinOut[7]}, 2'b10);
		$display("routing test done");
		summarize();
	end
endmodule : pfm_pin_mux_test
